// >>> src/pwd_params.svh
// Offsets, field positions, reset values and timing counts of the power-down controller
`ifndef PWD_PARAMS_SVH
`define PWD_PARAMS_SVH
`define PWD_CTRL_ADDR      14'h3fef
`define PWD_BIT_XTAL       15
`define PWD_BIT_FLAG       14
`define PWD_BIT_ENA        13
`define PWD_BIT_PUCR       12
`define PWD_CTRL_RESET     16'h0000
`define PWD_EXTERNAL_INTERRUPT_TWO_VECTOR    14'h0004
`define PWD_RESET_VECTOR   14'h0000
`define PWD_STACK_STATUS_REG_CLEAN    8'h55
`define PWD_SETTLE_CYCLES  4096
`define PWD_CLK_PERIOD_NS  10
`endif

// >>> src/pwd_pkg.sv
// Types shared by the power-down controller
package pwd_pkg;
	typedef enum logic [1:0] {
		DIV_16,
		DIV_32,
		DIV_64,
		DIV_128
	} idle_div_e;
	typedef logic [7:0] divcnt_t;
endpackage : pwd_pkg

// >>> src/pwd_if.sv
// Interface carrying the clock divider request and its enables
`timescale 1ns/1ns
interface clkdiv_if;
	logic        active;   // Divide while high
	logic [7:0]  divisor;  // Divide ratio minus one
	logic        tick;     // One-cycle enable of the slow clock
	modport ctrl (output active, output divisor, input tick);
	modport div  (input active, input divisor, output tick);
endinterface : clkdiv_if

// >>> src/clk_divider.sv
// Clock-enable divider used in divided-clock idle
`timescale 1ns/1ns
module clk_divider (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Divider control
	clkdiv_if.div     dv
);
	import pwd_pkg::*;
	// Count of input clocks, held at zero while not dividing
	divcnt_t cnt_r;
	divcnt_t cnt_nxt;
	logic    tick_r;
	assign cnt_nxt = (!dv.active || cnt_r == dv.divisor) ? 8'h00 : cnt_r + 8'h01;
	// Tick every cycle when not dividing, else once per divisor plus one cycles
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_r  <= 8'h00;
			tick_r <= 1'b1;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= !dv.active || (cnt_r == dv.divisor);
		end
	end
	assign dv.tick = tick_r;
endmodule : clk_divider

// >>> src/power_down_idle_control.sv
// Power-down and low-power idle controller of the processor core
`timescale 1ns/1ns
`include "pwd_params.svh"
module power_down_idle_control #(
	parameter int SETTLE_CYCLES = `PWD_SETTLE_CYCLES  // Settling count after wake
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Data memory register port
	input  wire logic [13:0]       dm_addr,
	input  wire logic              dm_wr,
	input  wire logic [15:0]       dm_wdata,
	output logic [15:0]            dm_rdata,
	// Core interrupt and instruction events
	input  wire logic              ext_int_two_pin,
	input  wire logic              int_force_two,
	input  wire logic              int_pending,
	input  wire logic              ack_vector,
	input  wire logic              exec_halt,
	input  wire logic              exec_halt_div,
	input  wire pwd_pkg::idle_div_e halt_div,
	input  wire logic              exec_rti,
	// Wake flag pin
	input  wire logic              wake_flag_pin,
	// Core control outputs
	output logic                   int_two_req,
	output logic [13:0]            vector_addr,
	output logic                   vector_load,
	output logic                   core_clk_en,
	output logic                   context_clear,
	output logic [7:0]             stack_status_reg_load,
	output logic                   core_waiting,
	// Divided clocks and pins
	output logic                   periph_clk_en,
	output logic                   power_down_ack_out,
	output logic                   xtal_off
);
	import pwd_pkg::*;

	// ********************************
	// Constants and checks
	// ********************************
	localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
	// Refuse a settling count the countdown cannot hold
	if (SETTLE_CYCLES < 1) begin : g_bad_settle
		$error("SETTLE_CYCLES must be at least one");
	end

	// Divisor minus one for each idle ratio
	function automatic logic [7:0] div_ratio(input idle_div_e d);
		unique case (d)
			DIV_16:  div_ratio = 8'h0f;
			DIV_32:  div_ratio = 8'h1f;
			DIV_64:  div_ratio = 8'h3f;
			DIV_128: div_ratio = 8'h7f;
		endcase
	endfunction : div_ratio

	// ********************************
	// Pin synchronisers
	// ********************************
	logic wf_s1_r, wf_s2_r, wf_d_r;    // Wake flag chain and edge history
	logic ir_s1_r, ir_s2_r;            // Interrupt two pin chain
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{wf_s1_r, wf_s2_r, wf_d_r, ir_s1_r, ir_s2_r} <= 5'h00;
		end else begin
			wf_s1_r <= wake_flag_pin;
			wf_s2_r <= wf_s1_r;
			wf_d_r  <= wf_s2_r;
			ir_s1_r <= ext_int_two_pin;
			ir_s2_r <= ir_s1_r;
		end
	end

	// ********************************
	// Control register
	// ********************************
	logic xtal_r, ena_r, pucr_r;      // Writable control bits
	logic [11:0] low_r;               // Autobuffer field, stored only
	wire  reg_hit = dm_wr && (dm_addr == `PWD_CTRL_ADDR);
	wire  flag_bit = ena_r && wf_s2_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{xtal_r, ena_r, pucr_r, low_r} <= 15'h0000;
		end else if (reg_hit) begin
			xtal_r <= dm_wdata[`PWD_BIT_XTAL];
			ena_r  <= dm_wdata[`PWD_BIT_ENA];
			pucr_r <= dm_wdata[`PWD_BIT_PUCR];
			low_r  <= dm_wdata[11:0];
		end
	end
	wire [15:0] rd_word = (dm_addr == `PWD_CTRL_ADDR) ?
		{xtal_r, flag_bit, ena_r, pucr_r, low_r} : 16'h0000;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dm_rdata <= `PWD_CTRL_RESET;
		end else begin
			dm_rdata <= rd_word;
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	typedef enum logic [2:0] {RUN, IN_ISR, IDLE_STD, IDLE_DIV, POWERED, SETTLE} st_e;
	st_e st_r, st_nxt;
	logic [SETTLE_W-1:0] settle_r;   // Settling countdown
	logic                pd_isr_r;   // Interrupt two routine is a power-down one

	wire irq_two  = ir_s2_r || int_force_two;
	wire wake_edge = ena_r && wf_s2_r && !wf_d_r;
	clkdiv_if dv();

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			RUN, IN_ISR: begin
				// Halt in enabled routine powers down
				if (exec_halt && st_r == IN_ISR && pd_isr_r) st_nxt = POWERED;
				else if (exec_halt) st_nxt = IDLE_STD;
				else if (exec_halt_div) st_nxt = IDLE_DIV;
				else if (exec_rti && st_r == IN_ISR) st_nxt = RUN;
				else if (ack_vector) st_nxt = IN_ISR;
			end
			IDLE_STD: if (int_pending) st_nxt = pd_isr_r ? IN_ISR : RUN;
			// Leave divided idle on slow tick
			IDLE_DIV: if (int_pending && dv.tick) st_nxt = pd_isr_r ? IN_ISR : RUN;
			POWERED:  if (wake_edge) st_nxt = SETTLE;
			SETTLE:   if (settle_r == SETTLE_W'(1)) st_nxt = pucr_r ? RUN : IN_ISR;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r     <= RUN;
			settle_r <= '0;
			pd_isr_r <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			settle_r <= (st_r == POWERED) ? SETTLE_W'(SETTLE_CYCLES) :
				(settle_r != '0 ? settle_r - SETTLE_W'(1) : settle_r);
			// Enable sampled when interrupt two is vectored
			if (ack_vector && irq_two && st_r == RUN) pd_isr_r <= ena_r;
			else if (exec_rti || (st_r == SETTLE && st_nxt != SETTLE && pucr_r)) pd_isr_r <= 1'b0;
		end
	end

	// ********************************
	// Divider and outputs
	// ********************************
	// Divisor from instruction
	assign dv.active  = (st_r == IDLE_DIV);
	assign dv.divisor = div_ratio(halt_div);
	clk_divider u_div (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.dv      (dv)
	);

	wire wake_done = (st_r == SETTLE) && (st_nxt != SETTLE);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_two_req        <= 1'b0;
			vector_addr        <= `PWD_RESET_VECTOR;
			vector_load        <= 1'b0;
			core_clk_en        <= 1'b1;
			context_clear      <= 1'b0;
			stack_status_reg_load         <= 8'h00;
			core_waiting       <= 1'b0;
			periph_clk_en      <= 1'b1;
			power_down_ack_out <= 1'b0;
			xtal_off           <= 1'b0;
		end else begin
			int_two_req   <= irq_two;
			// Vector to interrupt two, or zero on clean wake
			vector_load   <= (ack_vector && irq_two && (st_r == RUN)) || (wake_done && pucr_r);
			vector_addr   <= (wake_done && pucr_r) ? `PWD_RESET_VECTOR : `PWD_EXTERNAL_INTERRUPT_TWO_VECTOR;
			context_clear <= wake_done && pucr_r;
			stack_status_reg_load    <= `PWD_STACK_STATUS_REG_CLEAN;
			// Core clock gated until settled, runs freely in routine
			core_clk_en   <= (st_nxt != POWERED) && (st_nxt != SETTLE);
			core_waiting  <= (st_nxt == IDLE_STD) || (st_nxt == IDLE_DIV);
			periph_clk_en <= dv.tick && (st_nxt != POWERED) && (st_nxt != SETTLE);
			// Acknowledge in power-down, low when disabled
			power_down_ack_out <= ena_r && (st_nxt == POWERED);
			xtal_off      <= xtal_r && (st_nxt == POWERED);
		end
	end

	// ********************************
	// Checks
	// ********************************
	sequence s_wake; st_r == POWERED ##1 st_r == SETTLE; endsequence
	chk_ack_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ena_r |=> !power_down_ack_out) else $error("ack high while disabled");
	chk_flag_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(dm_addr == `PWD_CTRL_ADDR && !ena_r) |=> !dm_rdata[14]) else $error("flag not zero");
	chk_wake_settle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_wake |-> !core_clk_en) else $error("clock ran during settle");
	chk_rti_abort: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == IN_ISR && exec_rti && !exec_halt && !exec_halt_div) |=> st_r == RUN) else $error("rti not returned");
	chk_idle_resp: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == IDLE_STD && int_pending) |=> st_r != IDLE_STD) else $error("slow idle exit");
	chk_div_resp: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == IDLE_DIV && int_pending) |-> ##[1:129] st_r != IDLE_DIV) else $error("divided idle exit late");
	chk_pd_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == IN_ISR && pd_isr_r && exec_halt) |=> ##1 power_down_ack_out) else $error("no power-down ack");
	chk_gate_pd: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_r == POWERED |-> !core_clk_en) else $error("core clock in power-down");
endmodule : power_down_idle_control

// >>> bench/wake_partner.sv
// Model of the wake pin and interrupt source beside the block
`timescale 1ns/1ns
module wake_partner (
	// Commands from the bench
	input  wire logic irq_cmd,
	input  wire logic wake_cmd,
	// Pins toward the block
	output logic      ext_int_two_pin,
	output logic      wake_flag_pin
);
	// ****
	// Pin drivers
	// ****
	// Both pins idle low at time zero
	initial begin
		ext_int_two_pin = 1'b0;
		wake_flag_pin   = 1'b0;
	end
	// request follows the bench command
	// Moves 3 ns late so the edge is unrelated to the clock phase
	always @(irq_cmd) ext_int_two_pin <= #3 irq_cmd;
	always @(wake_cmd) wake_flag_pin <= #3 wake_cmd;
endmodule : wake_partner

// >>> bench/power_down_idle_control_tb.sv
// Self-checking bench of the power-down and idle controller
`timescale 1ns/1ns
`include "pwd_params.svh"
module power_down_idle_control_tb;
	import pwd_pkg::*;
	// ****
	// Signals and notes
	// ****
	localparam int SETTLE = 8;  // Short settle count keeps the run brief
	typedef struct {int id; logic [15:0] v;} note_s;
	note_s q[$];  // Expected results, oldest first
	event chk;
	int n_fail = 0;
	int n_compared = 0;
	logic sys_clk = 0, rst_n = 0, dm_wr = 0, int_force_two = 0, int_pending = 0;
	logic ack_vector = 0, exec_halt = 0, exec_halt_div = 0, exec_rti = 0, irq_cmd = 0, wake_cmd = 0;
	logic [13:0] dm_addr = '0;
	logic [15:0] dm_wdata = '0;
	idle_div_e halt_div = DIV_16;
	logic ext_int_two_pin, wake_flag_pin, int_two_req, vector_load, core_clk_en, context_clear;
	logic core_waiting, periph_clk_en, power_down_ack_out, xtal_off;
	logic [15:0] dm_rdata;
	logic [13:0] vector_addr;
	logic [7:0] stack_status_reg_load;
	always #5 sys_clk = ~sys_clk;
	wake_partner i_partner (.irq_cmd, .wake_cmd, .ext_int_two_pin, .wake_flag_pin);
	power_down_idle_control #(.SETTLE_CYCLES(SETTLE)) i_dut (.sys_clk, .rst_n, .dm_addr, .dm_wr,
		.dm_wdata, .dm_rdata, .ext_int_two_pin, .int_force_two, .int_pending, .ack_vector, .exec_halt,
		.exec_halt_div, .halt_div, .exec_rti, .wake_flag_pin, .int_two_req, .vector_addr, .vector_load,
		.core_clk_en, .context_clear, .stack_status_reg_load, .core_waiting, .periph_clk_en, .power_down_ack_out,
		.xtal_off);
	// ****
	// Monitor and tasks
	// ****
	// Output picked by item number
	function automatic logic [15:0] obs(int id);
		case (id)
			0: return dm_rdata;
			1: return {15'h0, power_down_ack_out};
			2: return {15'h0, core_clk_en};
			3: return {15'h0, xtal_off};
			4: return {2'h0, vector_addr};
			5: return {8'h0, stack_status_reg_load};
			6: return {15'h0, core_waiting};
			7: return {15'h0, int_two_req};
			8: return {15'h0, vector_load};
			10: return {15'h0, periph_clk_en};
			default: return {15'h0, context_clear};
		endcase
	endfunction : obs
	// Oldest note is compared with the output it names
	always @(chk) while (q.size() > 0) begin
		note_s n;
		n = q.pop_front();
		n_compared++;
		if (obs(n.id) !== n.v) begin
			n_fail++;
			$display("FAIL item %0d expected %h seen %h", n.id, n.v, obs(n.id));
		end
	end
	// Bounded wait for a value, then note it for the monitor
	task automatic wt(int id, logic [15:0] v, int n);
		for (int i = 0; i < n && obs(id) !== v; i++) @(negedge sys_clk);
		q.push_back('{id, v});
		->chk;
		#1;
	endtask : wt
	task automatic pl(ref logic s);
		@(negedge sys_clk) s = 1'b1;
		@(negedge sys_clk) s = 1'b0;
	endtask : pl
	task automatic wr(logic [15:0] d);
		@(negedge sys_clk) begin dm_addr = `PWD_CTRL_ADDR; dm_wdata = d; dm_wr = 1'b1; end
		@(negedge sys_clk) dm_wr = 1'b0;
	endtask : wr
	task automatic rd(logic [13:0] a, logic [15:0] e);
		@(negedge sys_clk) dm_addr = a;
		@(negedge sys_clk);
		wt(0, e, 1);
	endtask : rd
	// Power-down run: mode 0 wake, 1 wake with clean context, 2 reset
	task automatic pd(int mode, bit frc);
		logic [15:0] w;
		w = {3'b101, mode == 1, 12'($urandom)};
		wr(w);
		rd(`PWD_CTRL_ADDR, w);
		@(negedge sys_clk) if (frc) int_force_two = 1'b1; else irq_cmd = 1'b1;
		wt(7, 1, 6);
		pl(ack_vector);
		wt(8, 1, 3);
		wt(4, `PWD_EXTERNAL_INTERRUPT_TWO_VECTOR, 1);
		repeat ($urandom_range(1, 20)) @(negedge sys_clk);
		pl(exec_halt);
		wt(1, 1, 3);
		wt(2, 0, 1);
		wt(3, 1, 1);
		@(negedge sys_clk) begin irq_cmd = 1'b0; int_force_two = 1'b0; end
		if (mode == 2) begin
			@(negedge sys_clk) rst_n = 1'b0;
			repeat (2) @(negedge sys_clk);
			rst_n = 1'b1;
			wt(1, 0, 1);
			wt(2, 1, 1);
			rd(`PWD_CTRL_ADDR, `PWD_CTRL_RESET);
			return;
		end
		@(negedge sys_clk) wake_cmd = 1'b1;
		wt(1, 0, 8);
		wt(2, 0, 1);
		if (mode == 1) begin
			wt(9, 1, SETTLE + 8);
			wt(5, `PWD_STACK_STATUS_REG_CLEAN, 1);
			wt(4, `PWD_RESET_VECTOR, 1);
			wt(2, 1, 2);
		end else begin
			wt(2, 1, SETTLE + 8);
			wt(9, 0, 1);
			pl(exec_rti);
		end
		@(negedge sys_clk) wake_cmd = 1'b0;
	endtask : pd
	task print_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	// ****
	// Tests
	// ****
	initial begin
		void'($urandom(32'h55e5));
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		rd(`PWD_CTRL_ADDR, `PWD_CTRL_RESET);
		rd(14'h3fee, 16'h0000);
		$display("test reset done");
		for (int d = 0; d < 4; d++) begin
			halt_div = idle_div_e'(d[1:0]);
			pl(exec_halt_div);
			wt(6, 1, 4);
			wt(10, 0, 2);
			wt(10, 1, (16 << d) + 2);
			@(negedge sys_clk) int_pending = 1'b1;
			wt(6, 0, (16 << d) + 4);
			@(negedge sys_clk) int_pending = 1'b0;
		end
		pl(exec_halt);
		wt(6, 1, 4);
		@(negedge sys_clk) int_pending = 1'b1;
		wt(6, 0, 2);
		@(negedge sys_clk) int_pending = 1'b0;
		$display("test idle done");
		wake_cmd = 1'b1;
		wt(1, 0, 6);
		rd(`PWD_CTRL_ADDR, 16'h0000);
		wr(16'ha000);
		rd(`PWD_CTRL_ADDR, 16'he000);
		@(negedge sys_clk) wake_cmd = 1'b0;
		$display("test flag done");
		pd(0, 0);
		pd(1, 1);
		pd(2, 0);
		$display("test power_down done");
		wr(16'h2000);
		@(negedge sys_clk) irq_cmd = 1'b1;
		wt(7, 1, 6);
		pl(ack_vector);
		pl(exec_rti);
		pl(exec_halt);
		repeat (4) @(negedge sys_clk);
		wt(1, 0, 1);
		wt(6, 1, 2);
		@(negedge sys_clk) begin int_pending = 1'b1; irq_cmd = 1'b0; end
		wt(6, 0, 2);
		$display("test abort done");
		print_verdict;
	end
	// Watchdog well beyond the expected run
	initial begin
		#300000;
		n_fail++;
		print_verdict;
	end
endmodule : power_down_idle_control_tb
